//--- design/pcr_pkg.sv
// Package for the loop configuration register slice: offsets, field positions,
// reset values, timing counts and the configuration bundles sent to the loops.
// Assumes a 100 MHz APB clock and the analog loops living outside this block.
package pcr_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] PCR_OFF_A_FRACTION_POWER = 12'h008;
  localparam logic [11:0] PCR_OFF_A_SPREAD_CTRL    = 12'h00C;
  localparam logic [11:0] PCR_OFF_A_WAVE_TABLE     = 12'h010;
  localparam logic [11:0] PCR_OFF_D_DIVIDER_CTRL   = 12'h020;
  localparam logic [11:0] PCR_OFF_D_POWER_LOCK     = 12'h024;

  // ****************************************
  // Reset values and implemented-bit masks
  // ****************************************
  localparam logic [27:0] PCR_RST_A_FRACTION_POWER = 28'h0000001;
  localparam logic [15:0] PCR_RST_A_SPREAD_CTRL    = 16'h0007;
  localparam logic [15:0] PCR_RST_A_WAVE_TABLE     = 16'h7F00;
  localparam logic [15:0] PCR_RST_D_DIVIDER_CTRL   = 16'h1096;
  localparam logic [15:0] PCR_RST_D_POWER_LOCK     = 16'h1042;
  localparam logic [15:0] PCR_IMP_A_SPREAD_CTRL    = 16'h1FFF;
  localparam logic [15:0] PCR_IMP_A_WAVE_TABLE     = 16'hFF01;
  localparam logic [15:0] PCR_IMP_D_POWER_LOCK     = 16'hF1FF;
  localparam logic [3:0]  PCR_FULL_WORD_STRB       = 4'hF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PCR_MASK_LSB       = 16;
  localparam int PCR_A_MULTI_OFF    = 27;
  localparam int PCR_A_VCO_OFF      = 26;
  localparam int PCR_A_POST_OFF     = 25;
  localparam int PCR_A_DAC_OFF      = 24;
  localparam int PCR_A_FRAC_LSB     = 0;
  localparam int PCR_A_SPREAD_LSB   = 8;
  localparam int PCR_A_RATE_LSB     = 4;
  localparam int PCR_A_CENTER       = 3;
  localparam int PCR_A_MOD_RESET    = 2;
  localparam int PCR_A_MOD_BYPASS   = 1;
  localparam int PCR_A_INT_BYPASS   = 0;
  localparam int PCR_A_WAVE_MAX_LSB = 8;
  localparam int PCR_A_WAVE_SEL     = 0;
  localparam int PCR_D_BYPASS       = 15;
  localparam int PCR_D_PDIV1_LSB    = 12;
  localparam int PCR_D_FBDIV_LSB    = 0;
  localparam int PCR_D_PD_SEL       = 15;
  localparam int PCR_D_PD_REQ_B     = 14;
  localparam int PCR_D_PD_REQ_A     = 13;
  localparam int PCR_D_DSM_OFF      = 12;
  localparam int PCR_D_LOCK         = 10;
  localparam int PCR_D_PDIV2_LSB    = 6;
  localparam int PCR_D_REFDIV_LSB   = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          PCR_CLK_PERIOD_NS = 10;
  localparam int          PCR_RELOCK_PD_NS  = 1000;
  localparam int          PCR_LOCK_QUAL_NS  = 200;
  localparam logic [7:0]  PCR_RELOCK_PD_CYC =
    8'((PCR_RELOCK_PD_NS + PCR_CLK_PERIOD_NS - 1) / PCR_CLK_PERIOD_NS);
  localparam logic [7:0]  PCR_LOCK_QUAL_CYC =
    8'((PCR_LOCK_QUAL_NS + PCR_CLK_PERIOD_NS - 1) / PCR_CLK_PERIOD_NS);

  // ****************************************
  // Configuration bundles to the loops
  // ****************************************
  typedef struct packed {
    logic        multiphase_out_off;
    logic        vco_out_off;
    logic        divided_output_off;
    logic        noise_dac_off;
    logic [23:0] fraction;
    logic [4:0]  spread_amount;
    logic [3:0]  spread_rate_div;
    logic        center_spread;
    logic        modulator_reset;
    logic        modulator_module_bypass;
    logic        modulator_integration_bypass;
    logic [7:0]  wave_max_addr;
    logic        wave_external;
  } pcr_loop_a_cfg_t;

  typedef struct packed {
    logic        route_reference_input;
    logic [2:0]  first_output_divider;
    logic [11:0] feedback_div;
    logic [2:0]  second_output_divider;
    logic [5:0]  reference_div;
    logic        powerdown;
    logic        modulator_off;
  } pcr_loop_d_cfg_t;

endpackage : pcr_pkg

//--- design/pcr_regs.sv
// Register slice for two loops: APB slave, masked writes, power-down sequencing
// and lock status reporting. Assumes the lock indication arrives asynchronously
// from the analog loop and that the bus master issues plain APB transfers.
`timescale 1ns/10ps

// Function
// [RL1] Upper mask bits gate lower-half writes
// [RL2] Bypass bit routes reference input to output
// [RL3] Post dividers 1..7, zero refused
// [RL4] Software keeps feedback divider in range
// [RL5] Feedback divider used as-is, no increment
// [RL6] Select high: only request B powers down
// [RL7] Select low: divider change or request A
// [RL8] Bit 12 disables modulator, resets to one
// [RL9] Read-only lock bit shows lock state
// [RL10] Reference divider 1..63, zero refused
// [RL11] Fraction field adds value over 2^24
// [RL12] Bit 27 stops multiphase outputs
// [RL13] Bit 26 stops buffered oscillator output
// [RL14] Bit 25 stops all other outputs
// [RL15] Bit 24 stops noise cancellation converter
// [RL16] Spread amount 0.1 percent per unit
// [RL17] Bits 7:4 set modulation rate divider
// [RL18] Bit 3 picks down or center spread
// [RL19] Bit 2 holds modulator in reset
// [RL20] Bits 1,0 bypass modulator, reset one
// [RL21] Wave table max address, external select
// [RL22] Only full word accesses accepted; pstrb is checked on writes only, reads pass with any strobe
// [RL23] Lock reads zero until relocked
module pcr_regs
  import pcr_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  input  wire logic [2:0]       pprot,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             loop_d_lock_raw,
  output pcr_loop_a_cfg_t       loop_a_cfg,
  output pcr_loop_d_cfg_t       loop_d_cfg
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [27:0]     ra2_q, ra2_d;
  logic [15:0]     ra3_q, ra3_d;
  logic [15:0]     ra4_q, ra4_d;
  logic [15:0]     rd0_q, rd0_d;
  logic [15:0]     rd1_q, rd1_d;
  logic [31:0]     prdata_q, prdata_d;
  logic            pslverr_q, pslverr_d;
  logic            lock_s1_q, lock_s2_q;
  logic [7:0]      relock_q, relock_d;
  logic [7:0]      qual_q, qual_d;
  pcr_loop_a_cfg_t cfg_a_q, cfg_a_d;
  pcr_loop_d_cfg_t cfg_d_q, cfg_d_d;
  logic            setup_w;
  logic            access_w;
  logic            hit_w;
  logic            full_w;
  logic            wr_ok_w;
  logic            chg_evt_w;
  logic            pd_w;
  logic            lock_stat_w;

  // Masked update: lower bit changes only where its mask bit is set
  function automatic logic [15:0] pcr_masked(input logic [15:0] old_v, input logic [31:0] wd);
    pcr_masked = (old_v & ~wd[31:16]) | (wd[15:0] & wd[31:16]); // RL1
  endfunction : pcr_masked

  // ****************************************
  // Bus decode
  // ****************************************
  // Zero wait states; protection attributes are accepted but not checked
  assign pready   = 1'b1;
  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q;
  assign setup_w  = psel && !penable;
  assign access_w = psel && penable;
  assign hit_w    = (paddr == PCR_OFF_A_FRACTION_POWER) || (paddr == PCR_OFF_A_SPREAD_CTRL) ||
                    (paddr == PCR_OFF_A_WAVE_TABLE) || (paddr == PCR_OFF_D_DIVIDER_CTRL) ||
                    (paddr == PCR_OFF_D_POWER_LOCK);
  // Partial-lane writes would corrupt masked fields, so they are refused
  assign full_w   = !pwrite || (pstrb == PCR_FULL_WORD_STRB); // RL22
  assign wr_ok_w  = access_w && pready && pwrite && hit_w && full_w;

  // ****************************************
  // Register file
  // ****************************************
  // Next values of the stored fields and the read answer
  always_comb begin
    ra2_d     = ra2_q;
    ra3_d     = ra3_q;
    ra4_d     = ra4_q;
    rd0_d     = rd0_q;
    rd1_d     = rd1_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    chg_evt_w = 1'b0;
    if (setup_w) begin
      pslverr_d = !hit_w || !full_w; // RL22
      prdata_d  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          PCR_OFF_A_FRACTION_POWER: prdata_d = {4'h0, ra2_q};
          PCR_OFF_D_DIVIDER_CTRL:   prdata_d = {16'h0000, rd0_q};
          PCR_OFF_D_POWER_LOCK: begin
            prdata_d = {16'h0000, rd1_q};
            prdata_d[PCR_D_LOCK] = lock_stat_w; // RL9
          end
          // Write-only spread and wave registers read back as zero
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
    if (wr_ok_w) begin
      case (paddr)
        // No mask on this register: a write replaces every field
        PCR_OFF_A_FRACTION_POWER: ra2_d = pwdata[27:0];
        PCR_OFF_A_SPREAD_CTRL: ra3_d = pcr_masked(ra3_q, pwdata) & PCR_IMP_A_SPREAD_CTRL; // RL1
        PCR_OFF_A_WAVE_TABLE:  ra4_d = pcr_masked(ra4_q, pwdata) & PCR_IMP_A_WAVE_TABLE; // RL1
        PCR_OFF_D_DIVIDER_CTRL: begin
          rd0_d = pcr_masked(rd0_q, pwdata); // RL1
          if (rd0_d[PCR_D_PDIV1_LSB +: 3] == 3'h0) begin
            rd0_d[PCR_D_PDIV1_LSB +: 3] = rd0_q[PCR_D_PDIV1_LSB +: 3]; // RL3
          end
          chg_evt_w = rd0_d[PCR_D_FBDIV_LSB +: 12] != rd0_q[PCR_D_FBDIV_LSB +: 12]; // RL7
        end
        PCR_OFF_D_POWER_LOCK: begin
          // Lock bit is not storage; the mask keeps it zero here
          rd1_d = pcr_masked(rd1_q, pwdata) & PCR_IMP_D_POWER_LOCK; // RL9
          if (rd1_d[PCR_D_PDIV2_LSB +: 3] == 3'h0) begin
            rd1_d[PCR_D_PDIV2_LSB +: 3] = rd1_q[PCR_D_PDIV2_LSB +: 3]; // RL3
          end
          if (rd1_d[PCR_D_REFDIV_LSB +: 6] == 6'h00) begin
            rd1_d[PCR_D_REFDIV_LSB +: 6] = rd1_q[PCR_D_REFDIV_LSB +: 6]; // RL10
          end
          chg_evt_w = rd1_d[PCR_D_REFDIV_LSB +: 6] != rd1_q[PCR_D_REFDIV_LSB +: 6]; // RL7
        end
        default: ra2_d = ra2_q;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ra2_q     <= PCR_RST_A_FRACTION_POWER;
      ra3_q     <= PCR_RST_A_SPREAD_CTRL;
      ra4_q     <= PCR_RST_A_WAVE_TABLE;
      rd0_q     <= PCR_RST_D_DIVIDER_CTRL;
      rd1_q     <= PCR_RST_D_POWER_LOCK;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      ra2_q     <= ra2_d;
      ra3_q     <= ra3_d;
      ra4_q     <= ra4_d;
      rd0_q     <= rd0_d;
      rd1_q     <= rd1_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************
  // Lock input synchroniser
  // ****************************************
  // Lock comes straight from the analog loop, asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end else begin
      lock_s1_q <= loop_d_lock_raw;
      lock_s2_q <= lock_s1_q;
    end
  end

  // ****************************************
  // Power-down and relock sequencing
  // ****************************************
  // Source select decides which requests reach the loop
  assign pd_w = rd1_q[PCR_D_PD_SEL] ? rd1_q[PCR_D_PD_REQ_B] // RL6
                                    : (rd1_q[PCR_D_PD_REQ_A] || (relock_q != 8'h00)); // RL7
  // A stale lock level would pass at once, so lock must hold a full window
  assign lock_stat_w = (qual_q == PCR_LOCK_QUAL_CYC); // RL23

  // Divider-change pulse length and lock qualification count
  always_comb begin
    relock_d = relock_q;
    qual_d   = qual_q;
    if (chg_evt_w && !rd1_q[PCR_D_PD_SEL]) begin
      relock_d = PCR_RELOCK_PD_CYC; // RL7
    end else if (relock_q != 8'h00) begin
      relock_d = relock_q - 8'h01;
    end
    if (pd_w || chg_evt_w || !lock_s2_q) begin
      qual_d = 8'h00; // RL23
    end else if (qual_q != PCR_LOCK_QUAL_CYC) begin
      qual_d = qual_q + 8'h01;
    end
  end

  // Sequencing state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relock_q <= 8'h00;
      qual_q   <= 8'h00;
    end else begin
      relock_q <= relock_d;
      qual_q   <= qual_d;
    end
  end

  // ****************************************
  // Configuration outputs
  // ****************************************
  // Fields are passed unscaled; the loop applies them as ratios
  always_comb begin
    cfg_a_d.multiphase_out_off           = ra2_q[PCR_A_MULTI_OFF]; // RL12
    cfg_a_d.vco_out_off                  = ra2_q[PCR_A_VCO_OFF]; // RL13
    cfg_a_d.divided_output_off           = ra2_q[PCR_A_POST_OFF]; // RL14
    cfg_a_d.noise_dac_off                = ra2_q[PCR_A_DAC_OFF]; // RL15
    cfg_a_d.fraction                     = ra2_q[PCR_A_FRAC_LSB +: 24]; // RL11
    cfg_a_d.spread_amount                = ra3_q[PCR_A_SPREAD_LSB +: 5]; // RL16
    cfg_a_d.spread_rate_div              = ra3_q[PCR_A_RATE_LSB +: 4]; // RL17
    cfg_a_d.center_spread                = ra3_q[PCR_A_CENTER]; // RL18
    cfg_a_d.modulator_reset              = ra3_q[PCR_A_MOD_RESET]; // RL19
    cfg_a_d.modulator_module_bypass      = ra3_q[PCR_A_MOD_BYPASS]; // RL20
    cfg_a_d.modulator_integration_bypass = ra3_q[PCR_A_INT_BYPASS]; // RL20
    cfg_a_d.wave_max_addr                = ra4_q[PCR_A_WAVE_MAX_LSB +: 8]; // RL21
    cfg_a_d.wave_external                = ra4_q[PCR_A_WAVE_SEL]; // RL21
    cfg_d_d.route_reference_input        = rd0_q[PCR_D_BYPASS]; // RL2
    cfg_d_d.first_output_divider         = rd0_q[PCR_D_PDIV1_LSB +: 3];
    cfg_d_d.feedback_div                 = rd0_q[PCR_D_FBDIV_LSB +: 12]; // RL5
    cfg_d_d.second_output_divider        = rd1_q[PCR_D_PDIV2_LSB +: 3];
    cfg_d_d.reference_div                = rd1_q[PCR_D_REFDIV_LSB +: 6];
    cfg_d_d.powerdown                    = pd_w;
    cfg_d_d.modulator_off                = rd1_q[PCR_D_DSM_OFF]; // RL8
  end

  // Output flops; reset image matches the register reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Bundle field order follows the register bit order, so the images slice straight in
      cfg_a_q <= {PCR_RST_A_FRACTION_POWER, PCR_RST_A_SPREAD_CTRL[12:0],
                  PCR_RST_A_WAVE_TABLE[15:8], PCR_RST_A_WAVE_TABLE[0]};
      cfg_d_q <= {PCR_RST_D_DIVIDER_CTRL, PCR_RST_D_POWER_LOCK[8:0], 1'b0,
                  PCR_RST_D_POWER_LOCK[PCR_D_DSM_OFF]};
    end else begin
      cfg_a_q <= cfg_a_d;
      cfg_d_q <= cfg_d_d;
    end
  end

  assign loop_a_cfg = cfg_a_q;
  assign loop_d_cfg = cfg_d_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_mask_hold;
    wr_ok_w && (paddr == PCR_OFF_D_DIVIDER_CTRL) && !pwdata[PCR_MASK_LSB + PCR_D_BYPASS]
      |=> rd0_q[PCR_D_BYPASS] == $past(rd0_q[PCR_D_BYPASS]);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("unmasked bit changed"); // RL1

  property p_bypass_route;
    $rose(rd0_q[PCR_D_BYPASS]) |=> loop_d_cfg.route_reference_input;
  endproperty
  a_bypass_route: assert property (p_bypass_route) else $error("bypass not routed"); // RL2

  property p_postdiv_nonzero;
    (loop_d_cfg.first_output_divider != 3'h0) && (loop_d_cfg.second_output_divider != 3'h0);
  endproperty
  a_postdiv_nonzero: assert property (p_postdiv_nonzero) else $error("post divider zero"); // RL3

  property p_refdiv_nonzero;
    loop_d_cfg.reference_div != 6'h00;
  endproperty
  a_refdiv_nonzero: assert property (p_refdiv_nonzero) else $error("reference divider zero"); // RL10

  property p_fbdiv_direct;
    ##1 loop_d_cfg.feedback_div == $past(rd0_q[11:0]);
  endproperty
  a_fbdiv_direct: assert property (p_fbdiv_direct) else $error("feedback divider altered"); // RL5

  property p_sel_b_only;
    rd1_q[PCR_D_PD_SEL] && !rd1_q[PCR_D_PD_REQ_B] |=> !loop_d_cfg.powerdown;
  endproperty
  a_sel_b_only: assert property (p_sel_b_only) else $error("powerdown without request B"); // RL6

  property p_change_pd;
    chg_evt_w && !rd1_q[PCR_D_PD_SEL] |-> ##2 loop_d_cfg.powerdown [*8];
  endproperty
  a_change_pd: assert property (p_change_pd) else $error("divider change missed powerdown"); // RL7

  property p_req_a_pd;
    !rd1_q[PCR_D_PD_SEL] && rd1_q[PCR_D_PD_REQ_A] |=> loop_d_cfg.powerdown;
  endproperty
  a_req_a_pd: assert property (p_req_a_pd) else $error("request A ignored"); // RL7

  property p_lock_low_pd;
    pd_w || !lock_s2_q |=> !lock_stat_w;
  endproperty
  a_lock_low_pd: assert property (p_lock_low_pd) else $error("lock shown while down"); // RL23

  property p_lock_read;
    setup_w && !pwrite && (paddr == PCR_OFF_D_POWER_LOCK) |=> prdata[PCR_D_LOCK] == $past(lock_stat_w);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bit misreported"); // RL9

  property p_part_write;
    access_w && pwrite && (pstrb != PCR_FULL_WORD_STRB) |-> pslverr ##1 $stable({ra2_q, ra3_q, ra4_q, rd0_q, rd1_q});
  endproperty
  a_part_write: assert property (p_part_write) else $error("partial write accepted"); // RL22

  property p_spread_out;
    ##1 loop_a_cfg.modulator_reset == $past(ra3_q[PCR_A_MOD_RESET]);
  endproperty
  a_spread_out: assert property (p_spread_out) else $error("modulator reset mismatch"); // RL19

  property p_relock_count;
    (relock_q != 8'h00) && !chg_evt_w |=> relock_q == $past(relock_q) - 8'h01;
  endproperty
  a_relock_count: assert property (p_relock_count) else $error("relock count skipped"); // RL7

  property p_mod_off_out;
    ##1 loop_d_cfg.modulator_off == $past(rd1_q[PCR_D_DSM_OFF]);
  endproperty
  a_mod_off_out: assert property (p_mod_off_out) else $error("modulator disable mismatch"); // RL8

  property p_fraction_out;
    ##1 loop_a_cfg.fraction == $past(ra2_q[PCR_A_FRAC_LSB +: 24]);
  endproperty
  a_fraction_out: assert property (p_fraction_out) else $error("fraction mismatch"); // RL11

  property p_power_outs;
    ##1 {loop_a_cfg.multiphase_out_off, loop_a_cfg.vco_out_off, loop_a_cfg.divided_output_off,
         loop_a_cfg.noise_dac_off} == $past(ra2_q[PCR_A_MULTI_OFF -: 4]);
  endproperty
  a_power_outs: assert property (p_power_outs) else $error("output power-down mismatch"); // RL12 RL13 RL14 RL15

  property p_lock_qualified;
    $rose(lock_stat_w) |-> $past(lock_s2_q, 20);
  endproperty
  a_lock_qualified: assert property (p_lock_qualified) else $error("lock shown too early"); // RL23

  property p_cov_relock;
    chg_evt_w ##1 (relock_q != 8'h00);
  endproperty
  c_cov_relock: cover property (p_cov_relock);

  property p_cov_locked;
    $rose(lock_stat_w);
  endproperty
  c_cov_locked: cover property (p_cov_locked);

  property p_cov_err;
    access_w && pslverr;
  endproperty
  c_cov_err: cover property (p_cov_err);

  property p_cov_sel_b;
    rd1_q[PCR_D_PD_SEL] && loop_d_cfg.powerdown;
  endproperty
  c_cov_sel_b: cover property (p_cov_sel_b);

endmodule : pcr_regs

//--- verification/tb_pcr_regs.sv
// Self-checking bench for the loop configuration register slice.
// Assumes pcr_pkg and pcr_regs are compiled first; the bench is the APB master.
`timescale 1ns/10ps
module tb_pcr_regs
  import pcr_pkg::*;
();
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] r;
  } pcr_tb_row_t;

  logic            pclk;
  logic            presetn;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  logic [3:0]      pstrb;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            loop_d_lock_raw;
  pcr_loop_a_cfg_t loop_a_cfg;
  pcr_loop_d_cfg_t loop_d_cfg;
  logic [31:0]     r;
  logic            e;
  int              fails;
  int              n_compared;
  int              cyc;

  // Write, then read back; write-only registers read as zero
  pcr_tb_row_t rows [10] = '{
    '{12'h008, 32'h0ABCDEF5, 32'h0ABCDEF5},
    '{12'h00C, 32'hFFFF1AB8, 32'h00000000},
    '{12'h010, 32'hFFFFC301, 32'h00000000},
    '{12'h020, 32'hFFFFB0C8, 32'h0000B0C8},
    '{12'h020, 32'h00FF12FF, 32'h0000B0FF},
    '{12'h024, 32'h01FF0145, 32'h00001145},
    '{12'h024, 32'h10000000, 32'h00000145},
    '{12'h020, 32'h70000000, 32'h0000B0FF},
    '{12'h024, 32'h003F0000, 32'h00000145},
    '{12'h024, 32'h04000400, 32'h00000145}
  };

  pcr_regs u_pcr_regs (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .pstrb           (pstrb),
    .pprot           (3'h0),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .loop_d_lock_raw (loop_d_lock_raw),
    .loop_a_cfg      (loop_a_cfg),
    .loop_d_cfg      (loop_d_cfg)
  );

  // ****************************************
  // Clock and hang guard
  // ****************************************
  always #5 pclk = ~pclk;

  // Ceiling well above the roughly 470 cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count assumed; only the bench-wide ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        f;
    apb(1'b1, a, d, 4'hF, x, f);
    check(64'(f), 64'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic        f;
    apb(1'b0, a, 32'h0, 4'hF, x, f);
    check({31'h0, f, x}, {31'h0, 1'b0, exp});
  endtask : rd

  // Settled look at the power-down output n edges on
  task automatic pd_at(input int n, input logic exp);
    repeat (n) @(posedge pclk);
    #1;
    check(64'(loop_d_cfg.powerdown), 64'(exp));
  endtask : pd_at

  task automatic complete_run();
    $display("Counts: compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    pclk            = 1'b0;
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 12'h000;
    pwdata          = 32'h0;
    pstrb           = 4'hF;
    loop_d_lock_raw = 1'b0;
    fails           = 0;
    n_compared      = 0;
    cyc             = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    // Reset values at the outputs and through the bus
    check(64'(loop_a_cfg), 64'({4'h0, 24'h000001, 5'h00, 4'h0, 1'b0, 3'h7, 8'h7F, 1'b0}));
    check(64'(loop_d_cfg), 64'({1'b0, 3'h1, 12'h096, 3'h1, 6'h02, 1'b0, 1'b1}));
    rd(PCR_OFF_A_FRACTION_POWER, 32'h00000001);
    rd(PCR_OFF_A_SPREAD_CTRL, 32'h00000000);
    rd(PCR_OFF_A_WAVE_TABLE, 32'h00000000);
    rd(PCR_OFF_D_DIVIDER_CTRL, 32'h00001096);
    rd(PCR_OFF_D_POWER_LOCK, 32'h00001042);
    $display("test reset done");
    // Ordinary writes and readbacks from the table
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
    end
    // Let relock pulses run out before comparing whole bundles
    repeat (120) @(posedge pclk);
    #1;
    check(64'(loop_a_cfg), 64'({4'hA, 24'hBCDEF5, 5'h1A, 4'hB, 4'h8, 8'hC3, 1'b1}));
    check(64'(loop_d_cfg), 64'({1'b1, 3'h3, 12'h0FF, 3'h5, 6'h05, 1'b0, 1'b0}));
    $display("test table done");
    // Unmapped address and partial strobes are refused
    apb(1'b0, 12'h004, 32'h0, 4'hF, r, e);
    check({31'h0, e, r}, {31'h0, 1'b1, 32'h0});
    apb(1'b1, PCR_OFF_D_DIVIDER_CTRL, 32'hFFFF0000, 4'h3, r, e);
    check(64'(e), 64'h1);
    rd(PCR_OFF_D_DIVIDER_CTRL, 32'h0000B0FF);
    $display("test refusal done");
    // Divider change with select low gives a 100-cycle power-down; ratios stay in range
    wr(PCR_OFF_D_DIVIDER_CTRL, 32'h0FFF0064);
    pd_at(5, 1'b1);
    pd_at(90, 1'b1);
    pd_at(10, 1'b0);
    wr(PCR_OFF_D_POWER_LOCK, 32'h20002000);
    pd_at(3, 1'b1);
    wr(PCR_OFF_D_POWER_LOCK, 32'h20000000);
    pd_at(3, 1'b0);
    // Select high: request A and divider changes are ignored
    wr(PCR_OFF_D_POWER_LOCK, 32'hA000A000);
    pd_at(3, 1'b0);
    wr(PCR_OFF_D_DIVIDER_CTRL, 32'h0FFF0096);
    pd_at(3, 1'b0);
    wr(PCR_OFF_D_POWER_LOCK, 32'h40004000);
    pd_at(3, 1'b1);
    $display("test powerdown done");
    // Lock stays low while powered down, rises once running
    @(posedge pclk);
    loop_d_lock_raw <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(PCR_OFF_D_POWER_LOCK, 32'h0000E145);
    wr(PCR_OFF_D_POWER_LOCK, 32'h40000000);
    repeat (40) @(posedge pclk);
    rd(PCR_OFF_D_POWER_LOCK, 32'h0000A545);
    wr(PCR_OFF_D_POWER_LOCK, 32'h04000000);
    rd(PCR_OFF_D_POWER_LOCK, 32'h0000A545);
    @(posedge pclk);
    loop_d_lock_raw <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(PCR_OFF_D_POWER_LOCK, 32'h0000A145);
    $display("test lock done");
    // Mid-run reset must bring loaded registers back to their reset image
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check(64'(loop_d_cfg), 64'({1'b0, 3'h1, 12'h096, 3'h1, 6'h02, 1'b0, 1'b1}));
    rd(PCR_OFF_D_DIVIDER_CTRL, 32'h00001096);
    rd(PCR_OFF_D_POWER_LOCK, 32'h00001042);
    $display("test mid-run reset done");
    complete_run();
  end

endmodule : tb_pcr_regs
